// file: pwdg_top.sv
// Local design decisions: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module pwdg_top
  import pwdg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [CNT_W-1:0] MAX_TICKS = MAX_TIMEOUT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic refresh_strobe,
  input wire logic timeout_suppress,
  input wire logic supply_fault,
  output logic mcu_reset_n,
  output logic irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // stage 0 catches the pin, stages 1 and 2 vote on the level
  logic [2:0] refresh_sync;
  logic [2:0] suppress_sync;
  logic [2:0] fault_sync;
  logic refresh_level;
  logic suppress_level;
  logic fault_level;

  // three flops per pin, first one feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_sync <= SYNC_RST;
      suppress_sync <= SYNC_RST;
      fault_sync <= SYNC_RST;
    end else begin
      refresh_sync <= {refresh_sync[1:0], refresh_strobe};
      suppress_sync <= {suppress_sync[1:0], timeout_suppress};
      fault_sync <= {fault_sync[1:0], supply_fault};
    end
  end

  // level follows once second and third stages agree
  // a single-cycle glitch on a pin never reaches the level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_level <= 1'b0;
      suppress_level <= 1'b0;
      fault_level <= 1'b0;
    end else begin
      if (refresh_sync[1] == refresh_sync[2]) begin
        refresh_level <= refresh_sync[2];
      end
      if (suppress_sync[1] == suppress_sync[2]) begin
        suppress_level <= suppress_sync[2];
      end
      if (fault_sync[1] == fault_sync[2]) begin
        fault_level <= fault_sync[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // time base
  // ----------------------------------------------------------------
  // every watchdog count below advances on this tick only
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYCLES - 1);
  logic [CNT_W-1:0] tick_cnt;
  wire tick = (tick_cnt == TICK_LAST);

  // free-running tick divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= '0;
    end else begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // software control
  // ----------------------------------------------------------------
  logic [1:0] ctrl;
  pwdg_ev_t irq_stat;
  pwdg_ev_t irq_mask;

  // software suppress ors with the pin, force holds the reset state
  wire sw_suppress = ctrl[CTRL_SUPPRESS_BIT];
  wire sw_force = ctrl[CTRL_FORCE_BIT];
  wire suppress = suppress_level | sw_suppress;

  // ----------------------------------------------------------------
  // watchdog core
  // ----------------------------------------------------------------
  // count and high_width run in ticks, reload_period is their limit
  pwdg_state_t state;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] reload_period;
  logic [CNT_W-1:0] high_width;
  logic [CNT_W-1:0] rst_cnt;
  logic programmed;
  logic refresh_prev;
  pwdg_ev_t ev;

  wire refresh_rise = refresh_level & ~refresh_prev;
  wire refresh_fall = ~refresh_level & refresh_prev;
  // limits compare the next count, so a hit lands on the tick itself
  wire expire_hit = tick && (count + 1'b1 >= reload_period);
  wire stuck_hit = tick && (high_width + 1'b1 > reload_period);
  // programming only while unprogrammed and strictly between the limits
  wire prog_ok = !programmed
    && high_width > MIN_PROG_TICKS
    && high_width < MAX_TICKS;
  // pin fault or software force keeps the block in its reset state
  wire init_req = fault_level | sw_force;

  // one-cycle events into the sticky status
  assign ev.expired = (state == PWDG_LOW) && !refresh_rise && expire_hit && !suppress;
  assign ev.stuck_high = (state == PWDG_HIGH) && refresh_level && stuck_hit && !suppress;
  assign ev.programmed = (state == PWDG_HIGH) && refresh_fall && prog_ok;
  assign ev.suppressed = suppress && (
    ((state == PWDG_LOW) && !refresh_rise && expire_hit) ||
    ((state == PWDG_HIGH) && refresh_level && stuck_hit));

  // edge tracking of the filtered refresh level
  // starts low like the idle pin, so no false rise follows reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_prev <= 1'b0;
    end else begin
      refresh_prev <= refresh_level;
    end
  end

  // main sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= PWDG_RESET;
      count <= '0;
      // power-on reset restores the same maximum as any other reset
      reload_period <= MAX_TICKS;
      high_width <= '0;
      rst_cnt <= '0;
      programmed <= 1'b0;
    // expiry, stuck-high, fault and force all land in the reset state
    end else if (init_req || ev.expired || ev.stuck_high) begin
      state <= PWDG_RESET;
      count <= '0;
      reload_period <= MAX_TICKS;
      high_width <= '0;
      rst_cnt <= '0;
      programmed <= 1'b0;
    end else begin
      unique case (state)
        PWDG_RESET: begin
          // hold reset low for a fixed tick count
          if (tick) begin
            rst_cnt <= rst_cnt + 1'b1;
          end
          if (tick && rst_cnt + 1'b1 >= RST_PULSE_TICKS) begin
            count <= '0;
            high_width <= '0;
            state <= refresh_level ? PWDG_HIGH : PWDG_LOW;
          end
        end
        PWDG_LOW: begin
          // a refresh rise wins over an expiry on the same tick
          if (refresh_rise) begin
            count <= '0;
            high_width <= '0;
            state <= PWDG_HIGH;
          end else if (expire_hit) begin
            count <= '0; // suppressed expiry restarts the period
          end else if (tick) begin
            count <= count + 1'b1;
          end
        end
        PWDG_HIGH: begin
          // width is judged at the falling edge of the filtered level
          if (refresh_fall) begin
            if (prog_ok) begin
              reload_period <= high_width;
              programmed <= 1'b1;
            end
            count <= '0;
            state <= PWDG_LOW;
          end else if (stuck_hit) begin
            high_width <= '0; // suppressed: measure a fresh period
          end else if (tick) begin
            high_width <= high_width + 1'b1;
          end
        end
      endcase
    end
  end

  // reset output from a flop, low from power-on onward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mcu_reset_n <= 1'b0;
    end else begin
      // event terms pull the pin low on the edge that changes the state
      mcu_reset_n <= (state != PWDG_RESET) && !init_req
        && !ev.expired && !ev.stuck_high;
    end
  end

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  wire setup = psel & ~penable;
  wire access = psel & penable;
  wire wr = access & pwrite;

  // one register select per word offset, all twelve address bits decoded
  function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  wire hit_ctrl = reg_hit(paddr, CTRL_OFS);
  wire hit_state = reg_hit(paddr, STATE_OFS);
  wire hit_count = reg_hit(paddr, COUNT_OFS);
  wire hit_reload = reg_hit(paddr, RELOAD_OFS);
  wire hit_stat = reg_hit(paddr, IRQ_STAT_OFS);
  wire hit_mask = reg_hit(paddr, IRQ_MASK_OFS);
  wire mapped = hit_ctrl | hit_state | hit_count
    | hit_reload | hit_stat | hit_mask;
  wire [EV_W-1:0] clr = (wr && hit_stat) ? pwdata[EV_W-1:0] : '0;

  // zero-wait answers; unmapped addresses get an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;

  // read mux
  // state word: suppress, refresh level, programmed, reset pin, state code
  logic [31:0] rd_mux;
  assign rd_mux =
    hit_ctrl ? {30'h0, ctrl} :
    hit_state ? {26'h0, suppress, refresh_level, programmed,
      mcu_reset_n, state} :
    hit_count ? {16'h0, count} :
    hit_reload ? {16'h0, reload_period} :
    hit_stat ? {28'h0, irq_stat} :
    hit_mask ? {28'h0, irq_mask} : 32'h0;

  // read data captured in setup, shown in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (setup && !pwrite) begin
      prdata <= rd_mux;
    end
  end

  // control and mask writes
  // state, count and reload ignore writes without an error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      irq_mask <= IRQ_MASK_RST;
    end else if (wr && hit_ctrl) begin
      ctrl <= pwdata[1:0];
    end else if (wr && hit_mask) begin
      irq_mask <= pwdata[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------
  // sticky status, write one to clear, new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= IRQ_STAT_RST;
    end else begin
      irq_stat <= (irq_stat & ~clr) | ev;
    end
  end

  // level output, high while any unmasked status bit is set
  assign irq = |(irq_stat & irq_mask);

endmodule

// file: pwdg_pkg.sv
package pwdg_pkg;

  // ----------------------------------------------------------------
  // time base and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int TIME_BASE_NS = 1000;
  // clock cycles per time-base tick
  localparam int TICK_CYC = TIME_BASE_NS / CLK_PERIOD_NS;
  localparam int CNT_W = 16;
  // timeout limits, in ticks
  localparam logic [CNT_W-1:0] MAX_TIMEOUT_TICKS = 16'h03e8;
  localparam logic [CNT_W-1:0] MIN_PROG_TICKS = 16'h0064;
  localparam logic [CNT_W-1:0] RST_PULSE_TICKS = 16'h000a;

  // ----------------------------------------------------------------
  // register map, byte offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STATE_OFS = 12'h004;
  localparam logic [11:0] COUNT_OFS = 12'h008;
  localparam logic [11:0] RELOAD_OFS = 12'h00c;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h010;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h014;

  // ----------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_SUPPRESS_BIT = 0;
  localparam int CTRL_FORCE_BIT = 1;
  localparam int EV_W = 4;
  localparam logic [1:0] CTRL_RST = 2'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 4'h0;
  localparam logic [EV_W-1:0] IRQ_STAT_RST = 4'h0;
  localparam logic [2:0] SYNC_RST = 3'h0;

  // ----------------------------------------------------------------
  // watchdog states and event group
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PWDG_RESET,
    PWDG_LOW,
    PWDG_HIGH
  } pwdg_state_t;

  // sticky event bits, same layout in status and mask
  typedef struct packed {
    logic suppressed;
    logic programmed;
    logic stuck_high;
    logic expired;
  } pwdg_ev_t;

endpackage

// file: pwdg_asserts.sv
`timescale 1ns/1ps
// ----
// port checker
// ----
module pwdg_asserts
  import pwdg_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC,
  parameter logic [CNT_W-1:0] MAX_TICKS = MAX_TIMEOUT_TICKS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic refresh_strobe,
  input wire logic timeout_suppress,
  input wire logic supply_fault,
  input wire logic mcu_reset_n
);
  localparam int HI = TICK_CYCLES * (int'(MAX_TICKS) + 2) + 8;
  localparam int LO = TICK_CYCLES * (int'(MIN_PROG_TICKS) - 5);
  localparam int PW = TICK_CYCLES * int'(RST_PULSE_TICKS) - 4;
  localparam int PS = 2 * TICK_CYCLES + 8;
  logic last;
  int quiet;
  // cycles since the last refresh edge while resets may fire
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last <= 1'b0;
      quiet <= 0;
    end else begin
      last <= refresh_strobe;
      quiet <= (!mcu_reset_n || timeout_suppress || refresh_strobe != last) ? 0 : quiet + 1;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_release_hold: assert property ($rose(presetn) |-> !mcu_reset_n [*8])
    else $error("no reset pulse after release");
  a_fault_hold: assert property (supply_fault [*8] |-> !mcu_reset_n)
    else $error("fault without reset");
  a_pulse_len: assert property ($fell(mcu_reset_n) && !supply_fault |->
    (!mcu_reset_n throughout ##PW 1'b1) ##[0:PS] mcu_reset_n) else $error("bad pulse length");
  a_start_run: assert property ($rose(mcu_reset_n) && !supply_fault |=> mcu_reset_n [*8])
    else $error("reset right after release");
  a_low_expiry: assert property (mcu_reset_n && !refresh_strobe |-> quiet <= HI)
    else $error("late expiry");
  a_high_expiry: assert property (mcu_reset_n && refresh_strobe |-> quiet <= HI)
    else $error("late stuck reset");
  a_no_early: assert property ($fell(mcu_reset_n) && !supply_fault |-> quiet >= LO)
    else $error("early reset");
  a_inhibit_hold: assert property (timeout_suppress && $past(timeout_suppress, 8) &&
    !supply_fault && $past(mcu_reset_n) |-> mcu_reset_n) else $error("reset while inhibited");
endmodule
bind pwdg_top pwdg_asserts #(.TICK_CYCLES(TICK_CYCLES), .MAX_TICKS(MAX_TICKS)) pwdg_asserts_inst (
  .pclk(pclk), .presetn(presetn), .refresh_strobe(refresh_strobe),
  .timeout_suppress(timeout_suppress), .supply_fault(supply_fault), .mcu_reset_n(mcu_reset_n));

// file: pwdg_mcu_model.sv
`timescale 1ns/1ps
// ----
// mcu model on the refresh line
// ----
module pwdg_mcu_model (
  input wire logic pclk,
  input wire logic mcu_reset_n,
  input wire logic start,
  input wire logic stick,
  input wire logic [15:0] pulse_cyc,
  output logic refresh_strobe
);
  logic [15:0] left;
  initial refresh_strobe = 1'b0;
  // pulse timer, dropped at once by a watchdog reset
  always @(posedge pclk) begin
    if (!mcu_reset_n) begin
      left <= 16'h0000;
      refresh_strobe <= 1'b0;
    end else if (start) begin
      left <= pulse_cyc - 16'h0001;
      refresh_strobe <= 1'b1;
    end else begin
      left <= (left != 16'h0000) ? left - 16'h0001 : 16'h0000;
      refresh_strobe <= stick || left != 16'h0000;
    end
  end
endmodule

// file: pwdg_tb.sv
`timescale 1ns/1ps
// ----
// watchdog bench
// ----
module pwdg_tb;
  import pwdg_pkg::*;
  localparam int TC = 4;
  localparam logic [CNT_W-1:0] MT = 16'h00c8;
  localparam int M = int'(MT);
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, start, stick;
  logic timeout_suppress, supply_fault, mcu_reset_n, refresh_strobe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] pulse_cyc;
  int err_total, num_checks, w, cyc;
  pwdg_top #(.TICK_CYCLES(TC), .MAX_TICKS(MT)) pwdg_top_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .refresh_strobe(refresh_strobe), .timeout_suppress(timeout_suppress),
    .supply_fault(supply_fault), .mcu_reset_n(mcu_reset_n), .irq(irq));
  pwdg_mcu_model pwdg_mcu_model_inst (.pclk(pclk), .mcu_reset_n(mcu_reset_n), .start(start),
    .stick(stick), .pulse_cyc(pulse_cyc), .refresh_strobe(refresh_strobe));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ticks to clock cycles at the bench tick rate
  function automatic int to_cyc(input int t);
    return t * TC;
  endfunction
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // range compare, an unknown value misses
  task automatic near(input string nm, input logic [31:0] lo, hi, got);
    num_checks++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, got);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      err_total++;
      summarize();
    end
  endtask
  // cycles until the mcu reset line reaches a level
  task automatic watch(input logic lv, input int lim);
    cyc = 0;
    while (mcu_reset_n !== lv) begin
      @(negedge pclk);
      cyc++;
      if (cyc > lim) begin
        err_total++;
        summarize();
      end
    end
  endtask
  task automatic pulse(input int p);
    @(posedge pclk);
    start <= 1'b1;
    pulse_cyc <= p[15:0];
    @(posedge pclk);
    start <= 1'b0;
    repeat (p + 6) @(posedge pclk);
  endtask
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, start, stick, timeout_suppress, supply_fault} = '0;
    {paddr, pwdata, pulse_cyc} = '0;
    err_total = 0;
    num_checks = 0;
    void'($urandom(51));
    repeat (6) @(posedge pclk);
    near("rst in reset", 0, 0, {31'h0, mcu_reset_n});
    presetn <= 1'b1;
    watch(1'b1, 20 * TC);
    near("release pulse", 9 * TC, 12 * TC, cyc);
    apb(1'b1, IRQ_MASK_OFS, 32'h0000000f);
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("reload", M, M, rd);
    apb(1'b0, 12'h100, 32'h0);
    near("unmapped", 1, 1, {31'h0, er});
    apb(1'b1, CTRL_OFS, 32'h00000001);
    apb(1'b0, CTRL_OFS, 32'h0);
    near("ctrl", 1, 1, rd);
    apb(1'b1, CTRL_OFS, 32'h0);
    for (int i = 0; i < 6; i++) begin
      repeat ($urandom_range(TC * 150, TC * 40)) @(posedge pclk);
      pulse($urandom_range(TC * 20, 2));
    end
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    near("no expiry", 0, 0, {31'h0, rd[0]});
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("short pulses", M, M, rd);
    watch(1'b0, TC * (M + 20));
    near("expiry", TC * (M - 5), TC * (M + 2) + 8, cyc);
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    near("stat", 1, 1, rd);
    near("irq on", 1, 1, {31'h0, irq});
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    @(negedge pclk);
    near("irq masked", 0, 0, {31'h0, irq});
    apb(1'b1, IRQ_MASK_OFS, 32'h0000000f);
    apb(1'b1, IRQ_STAT_OFS, 32'h00000001);
    @(negedge pclk);
    near("irq cleared", 0, 0, {31'h0, irq});
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("reload max", M, M, rd);
    watch(1'b1, 20 * TC);
    w = $urandom_range(M - 30, 110);
    pulse(w * TC);
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("programmed", w - 2, w + 2, rd);
    pulse((w - 5) * TC);
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("no reprogram", w - 2, w + 2, rd);
    watch(1'b0, TC * (M + 20));
    near("short expiry", TC * (w - 5), TC * (w + 2) + 8, cyc);
    watch(1'b1, 20 * TC);
    @(posedge pclk);
    stick <= 1'b1;
    watch(1'b0, TC * (M + 20));
    near("stuck high", TC * (M - 5), TC * (M + 2) + 8, cyc);
    @(posedge pclk);
    stick <= 1'b0;
    watch(1'b1, 20 * TC);
    @(posedge pclk);
    timeout_suppress <= 1'b1;
    repeat (TC * (M + 50)) @(posedge pclk);
    near("inhibit", 1, 1, {31'h0, mcu_reset_n});
    apb(1'b0, IRQ_STAT_OFS, 32'h0);
    near("suppressed", 1, 1, {31'h0, rd[3]});
    pulse(TC * 10);
    timeout_suppress <= 1'b0;
    supply_fault <= 1'b1;
    repeat (20) @(posedge pclk);
    near("fault", 0, 0, {31'h0, mcu_reset_n});
    supply_fault <= 1'b0;
    watch(1'b1, 20 * TC);
    near("fault release", 9 * TC, 12 * TC, cyc);
    w = $urandom_range(M - 30, 110);
    pulse(w * TC);
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("program after reset", w - 2, w + 2, rd);
    repeat (TC * (w - 12)) @(posedge pclk);
    apb(1'b1, CTRL_OFS, 32'h00000002);
    repeat (3) @(posedge pclk);
    near("force", 0, 0, {31'h0, mcu_reset_n});
    apb(1'b1, CTRL_OFS, 32'h0);
    watch(1'b1, to_cyc(20));
    near("force release", to_cyc(9), to_cyc(12), cyc);
    apb(1'b0, RELOAD_OFS, 32'h0);
    near("reload restored", M, M, rd);
    summarize();
  end
endmodule
